// ==== pkg/qlw_pkg.sv ====
// Shared constants and types of the quad line transceiver wake-up block.
package qlw_pkg;
   // Port count and clock.
   localparam int NP     = 4;
   localparam int CLK_NS = 20;

   // Times in their printed units.
   localparam int OC_STD_US   = 15;
   localparam int OC_SIO_US   = 480;
   localparam int SENSE_US    = 5;
   localparam int PULSE_US    = 80;
   localparam int COOL_US     = 8300;
   localparam int FLT_FAST_NS = 600;
   localparam int FLT_MID_NS  = 2800;
   localparam int FLT_SLOW_NS = 20300;

   // Cycle counts, rounded up to whole cycles.
   localparam int OC_STD_CYC   = (OC_STD_US * 1000 + CLK_NS - 1) / CLK_NS;
   localparam int OC_SIO_CYC   = (OC_SIO_US * 1000 + CLK_NS - 1) / CLK_NS;
   localparam int SENSE_CYC    = (SENSE_US * 1000 + CLK_NS - 1) / CLK_NS;
   localparam int PULSE_CYC    = (PULSE_US * 1000 + CLK_NS - 1) / CLK_NS;
   localparam int COOL_CYC     = (COOL_US * 1000 + CLK_NS - 1) / CLK_NS;
   localparam int FLT_FAST_CYC = (FLT_FAST_NS + CLK_NS - 1) / CLK_NS;
   localparam int FLT_MID_CYC  = (FLT_MID_NS + CLK_NS - 1) / CLK_NS;
   localparam int FLT_SLOW_CYC = (FLT_SLOW_NS + CLK_NS - 1) / CLK_NS;

   // Counter and bus widths.
   localparam int OC_W  = 15;
   localparam int FLT_W = 10;
   localparam int WK_W  = 20;
   localparam int AW    = 3;
   localparam int DW    = 16;

   // Register offsets.
   localparam logic [AW-1:0] A_DRV  = 3'h0;
   localparam logic [AW-1:0] A_FLT  = 3'h1;
   localparam logic [AW-1:0] A_SINK = 3'h2;
   localparam logic [AW-1:0] A_CTRL = 3'h3;
   localparam logic [AW-1:0] A_WAKE = 3'h4;
   localparam logic [AW-1:0] A_EVT  = 3'h5;
   localparam logic [AW-1:0] A_MASK = 3'h6;
   localparam logic [AW-1:0] A_STAT = 3'h7;

   // Field positions.
   localparam int DRV_EN_LSB   = 0;
   localparam int DRV_SLEW_LSB = 4;
   localparam int DRV_SIO_LSB  = 8;
   localparam int CTRL_FIX_BIT = 0;

   // Glitch filter selector codes and the sink-off code.
   localparam logic [1:0] FLT_OFF  = 2'h0;
   localparam logic [1:0] FLT_SLOW = 2'h1;
   localparam logic [1:0] FLT_MID  = 2'h2;
   localparam logic [1:0] FLT_FAST = 2'h3;
   localparam logic [1:0] SINK_OFF = 2'h0;

   // Positions in the synchroniser vector.
   localparam int SY_TXD  = 0;
   localparam int SY_DRIVER_ENABLE_PIN = 4;
   localparam int SY_LINE = 8;
   localparam int SY_ILIM = 12;
   localparam int SY_OT   = 16;
   localparam int SY_TSD  = 17;
   localparam int SY_W    = 18;

   typedef enum logic [2:0] {
      WK_IDLE  = 3'h0,
      WK_SENSE = 3'h1,
      WK_PULSE = 3'h3,
      WK_COOL  = 3'h2,
      WK_HOLD  = 3'h4
   } qlw_wk_t;

   typedef struct packed {
      logic [AW-1:0] addr;
      logic [DW-1:0] wdata;
      logic          wr;
      logic          rd;
   } qlw_bus_t;

   typedef struct packed {
      logic [NP-1:0] o;
      logic [NP-1:0] oe;
   } qlw_line_t;
endpackage

// ==== core/qlw_top.sv ====
// Quad line transceiver control with automatic wake pulse sequencer.
//
// Chosen here: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps

module qlw_top #(
   parameter int SIO_TRIP_CYC = qlw_pkg::OC_SIO_CYC,
   parameter int COOL_WAIT_CYC = qlw_pkg::COOL_CYC
) (
   // Clock and reset
   input  wire logic                               SYS_CLK,
   input  wire logic                               RST,
   // Host transceiver pins
   input  wire logic [qlw_pkg::NP-1:0]             TXD,
   input  wire logic [qlw_pkg::NP-1:0]             DRIVER_ENABLE_PIN,
   output logic      [qlw_pkg::NP-1:0]             RXD,
   output logic                                    RXD_ACTIVE,
   // Register port
   input  wire qlw_pkg::qlw_bus_t                  BUS,
   output logic      [qlw_pkg::DW-1:0]             REG_RDATA,
   // Interrupt pin, open drain
   output logic                                    IRQ_O,
   output logic                                    IRQ_OE,
   // Line pins
   input  wire logic [qlw_pkg::NP-1:0]             LINE_IN,
   output qlw_pkg::qlw_line_t                      LINE,
   // Analog front end
   input  wire logic [qlw_pkg::NP-1:0]             ILIM,
   input  wire logic                               OVERTEMP,
   input  wire logic                               THERM_SHDN,
   output logic      [qlw_pkg::NP-1:0][1:0]        SINK_SEL,
   output logic      [qlw_pkg::NP-1:0]             SLEW_FAST,
   output logic                                    THRESH_TRACK
);
   import qlw_pkg::*;

   typedef struct packed {
      logic [SY_W-1:0]            s1;
      logic [SY_W-1:0]            s2;
      logic [NP-1:0]              drv_en;
      logic [NP-1:0]              slew;
      logic [NP-1:0]              standard_io_mode;
      logic [NP-1:0][1:0]         flt;
      logic [NP-1:0][1:0]         sink;
      logic                       fixed;
      logic [NP-1:0]              wake;
      logic [NP-1:0]              wlatch;
      logic                       wpend;
      logic [NP-1:0]              evt;
      logic [NP-1:0]              mask;
      logic [NP-1:0]              filt;
      logic [NP-1:0][FLT_W-1:0]   fcnt;
      logic [NP-1:0][OC_W-1:0]    occ;
      qlw_wk_t                    wk;
      logic [WK_W-1:0]            wcnt;
      logic [1:0]                 gport;
      logic                       pol;
      logic [NP-1:0]              rxd;
      logic                       rx_on;
      logic [NP-1:0]              lo;
      logic [NP-1:0]              loe;
      logic [NP-1:0][1:0]         sink_out;
      logic                       irq;
      logic [DW-1:0]              rdata;
   } qlw_state_t;

   qlw_state_t                    q;
   qlw_state_t                    n;
   logic [NP-1:0]                 txd_s;
   logic [NP-1:0]                 driver_enable_pin_s;
   logic [NP-1:0]                 line_s;
   logic [NP-1:0]                 ilim_s;
   logic                          ot_s;
   logic                          tsd_s;
   logic                          underway;
   logic                          on_wake;
   logic                          act;
   logic [1:0]                    p;
   logic [OC_W-1:0]               oc_lim;
   logic [FLT_W-1:0]              f_lim;

   // Lowest-numbered requesting port.
   function automatic logic [1:0] lowest(input logic [NP-1:0] req);
      logic [1:0] r;
      r = 2'h0;
      for (int k = NP - 1; k >= 0; k--) begin
         if (req[k]) begin
            r = 2'(k);
         end
      end
      return r;
   endfunction

   // Filter delay in cycles for a selector code.
   function automatic logic [FLT_W-1:0] flt_len(input logic [1:0] code);
      logic [FLT_W-1:0] r;
      case (code)
         FLT_SLOW: r = FLT_W'(FLT_SLOW_CYC);
         FLT_MID:  r = FLT_W'(FLT_MID_CYC);
         FLT_FAST: r = FLT_W'(FLT_FAST_CYC);
         default:  r = FLT_W'(1);
      endcase
      return r;
   endfunction

   always_comb begin
      n = q;
      p = 2'h0;
      on_wake = 1'b0;
      act = 1'b0;
      oc_lim = '0;
      f_lim = '0;

      // Every transceiver, line and analog input passes two flops before use; the bus and reset do not.
      n.s1 = {THERM_SHDN, OVERTEMP, ILIM, LINE_IN, DRIVER_ENABLE_PIN, TXD};
      n.s2 = q.s1;
      txd_s = q.s2[SY_TXD +: NP];
      driver_enable_pin_s = q.s2[SY_DRIVER_ENABLE_PIN +: NP];
      line_s = q.s2[SY_LINE +: NP];
      ilim_s = q.s2[SY_ILIM +: NP];
      ot_s = q.s2[SY_OT];
      tsd_s = q.s2[SY_TSD];

      // Receivers leave their high-impedance state after reset.
      n.rx_on = 1'b1;

      underway = (q.wk == WK_HOLD) || (q.wk == WK_SENSE) ||
                 (q.wk == WK_PULSE);

      // A written request waits one cycle in its latch, then updates unless a wake is underway, which drops it.
      if (q.wpend) begin
         if (!underway) begin
            n.wake = q.wake | q.wlatch;
         end
         n.wlatch = '0;
         n.wpend = 1'b0;
      end

      if (BUS.wr) begin
         case (BUS.addr)
            A_DRV: begin
               n.drv_en = BUS.wdata[DRV_EN_LSB +: NP];
               n.slew = BUS.wdata[DRV_SLEW_LSB +: NP];
               n.standard_io_mode = BUS.wdata[DRV_SIO_LSB +: NP];
            end
            A_FLT: begin
               n.flt = BUS.wdata[2*NP-1:0];
            end
            A_SINK: begin
               n.sink = BUS.wdata[2*NP-1:0];
            end
            A_CTRL: begin
               n.fixed = BUS.wdata[CTRL_FIX_BIT];
            end
            A_WAKE: begin
               n.wlatch = BUS.wdata[NP-1:0];
               n.wpend = 1'b1;
            end
            A_EVT: begin
               // Writing zero clears an event; a new trip still wins below.
               n.evt = q.evt & BUS.wdata[NP-1:0];
            end
            A_MASK: begin
               n.mask = BUS.wdata[NP-1:0];
            end
            default: begin
            end
         endcase
      end

      // Wake sequencer shared by all ports, so only one can run.
      case (q.wk)
         WK_IDLE: begin
            if (q.fixed && (|q.wake)) begin
               p = lowest(q.wake);
               n.gport = p;
               n.wake[p] = 1'b0;
               n.wcnt = '0;
               n.wk = ot_s ? WK_HOLD : WK_SENSE;
            end
         end
         WK_HOLD: begin
            if (!ot_s) begin
               n.wk = WK_SENSE;
               n.wcnt = '0;
            end
         end
         WK_SENSE: begin
            if (q.wcnt == WK_W'(SENSE_CYC - 1)) begin
               // Pulse opposes the level the line rests at.
               n.pol = ~line_s[q.gport];
               n.wk = WK_PULSE;
               n.wcnt = '0;
            end else begin
               n.wcnt = q.wcnt + 1'b1;
            end
         end
         WK_PULSE: begin
            if (q.wcnt == WK_W'(PULSE_CYC - 1)) begin
               n.wk = WK_COOL;
               n.wcnt = '0;
            end else begin
               n.wcnt = q.wcnt + 1'b1;
            end
         end
         WK_COOL: begin
            if (q.wcnt == WK_W'(COOL_WAIT_CYC - 1)) begin
               n.wk = WK_IDLE;
               n.wcnt = '0;
            end else begin
               n.wcnt = q.wcnt + 1'b1;
            end
         end
         default: begin
            n.wk = WK_IDLE;
            n.wcnt = '0;
         end
      endcase

      for (int i = 0; i < NP; i++) begin
         on_wake = underway && (q.gport == 2'(i));
         // A tripped breaker keeps the driver off, save for a wake pulse on the port, until the event clears.
         act = (driver_enable_pin_s[i] | q.drv_en[i]) & ~q.evt[i];

         // Breaker: counts only while limiting without a break.
         oc_lim = q.standard_io_mode[i] ? OC_W'(SIO_TRIP_CYC - 1) :
                             OC_W'(OC_STD_CYC - 1);
         if (on_wake) begin
            n.occ[i] = q.occ[i];
         end else if (act && ilim_s[i]) begin
            if (q.occ[i] >= oc_lim) begin
               n.evt[i] = 1'b1;
               n.occ[i] = '0;
            end else begin
               n.occ[i] = q.occ[i] + 1'b1;
            end
         end else begin
            n.occ[i] = '0;
         end

         // Line drive; the prior driver state returns once wake ends.
         if (on_wake) begin
            n.lo[i] = q.pol;
            n.loe[i] = (q.wk == WK_PULSE) && !tsd_s;
         end else begin
            n.lo[i] = ~txd_s[i];
            n.loe[i] = act;
         end

         n.sink_out[i] = (act || on_wake) ? SINK_OFF :
                                            q.sink[i];

         // Filter follows the line only after it held for the delay.
         f_lim = flt_len(q.flt[i]) - 1'b1;
         if (q.flt[i] == FLT_OFF) begin
            n.filt[i] = line_s[i];
            n.fcnt[i] = '0;
         end else if (line_s[i] == q.filt[i]) begin
            n.fcnt[i] = '0;
         end else if (q.fcnt[i] >= f_lim) begin
            n.filt[i] = line_s[i];
            n.fcnt[i] = '0;
         end else begin
            n.fcnt[i] = q.fcnt[i] + 1'b1;
         end
         n.rxd[i] = ~n.filt[i];
      end

      n.irq = |(n.evt & q.mask);

      n.rdata = '0;
      if (BUS.rd) begin
         case (BUS.addr)
            A_DRV:  n.rdata = DW'({q.standard_io_mode, q.slew, q.drv_en});
            A_FLT:  n.rdata = DW'(q.flt);
            A_SINK: n.rdata = DW'(q.sink);
            A_CTRL: n.rdata = DW'(q.fixed);
            A_WAKE: n.rdata = DW'(q.wake | q.wlatch);
            A_EVT:  n.rdata = DW'(q.evt);
            A_MASK: n.rdata = DW'(q.mask);
            A_STAT: n.rdata = DW'({q.gport, tsd_s, ot_s,
                                   (q.wk == WK_COOL), underway});
            default: n.rdata = '0;
         endcase
      end
   end

   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   assign RXD = q.rxd;
   assign RXD_ACTIVE = q.rx_on;
   assign REG_RDATA = q.rdata;
   assign IRQ_O = 1'b0;
   assign IRQ_OE = q.irq;
   assign LINE.o = q.lo;
   assign LINE.oe = q.loe;
   assign SINK_SEL = q.sink_out;
   // The analog edge shaper gives 0.5 us when high and 3 us when low.
   assign SLEW_FAST = q.slew;
   assign THRESH_TRACK = ~q.fixed;
endmodule

// ==== sim/qlw_top_props.sv ====
// Port checker of the quad line transceiver wake-up block.
`timescale 1ns/10ps
module qlw_top_props #(
   parameter int SIO_TRIP_CYC  = 40,
   parameter int COOL_WAIT_CYC = 50
) (
   // Clock and reset
   input wire logic                          SYS_CLK,
   input wire logic                          RST,
   // Watched ports
   input wire logic [qlw_pkg::NP-1:0]        TXD,
   input wire logic [qlw_pkg::NP-1:0]        DRIVER_ENABLE_PIN,
   input wire logic                          RXD_ACTIVE,
   input wire qlw_pkg::qlw_bus_t             BUS,
   input wire qlw_pkg::qlw_line_t            LINE,
   input wire logic [qlw_pkg::NP-1:0]        ILIM,
   input wire logic [qlw_pkg::NP-1:0][1:0]   SINK_SEL,
   input wire logic [qlw_pkg::NP-1:0]        SLEW_FAST
);
   import qlw_pkg::*;
   logic [NP-1:0] tx1, tx2, tx3, en1, en2, en3, den_q, den_p, slw_q;
   logic [NP-1:0] wk_oe, nz;
   logic [19:0]   oc_n, wk_n, gap_n;
   logic          sio_q, seen_q;
   // Driving with no enable in sight can only be a wake pulse.
   assign wk_oe = LINE.oe & ~(DRIVER_ENABLE_PIN | en1 | en2 | en3 | den_q | den_p);
   always_comb begin
      for (int i = 0; i < NP; i++) nz[i] = |SINK_SEL[i];
   end
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         {tx1, tx2, tx3, en1, en2, en3, den_q, den_p, slw_q} <= '0;
         {oc_n, wk_n, gap_n, sio_q, seen_q} <= '0;
      end else begin
         {tx3, tx2, tx1} <= {tx2, tx1, TXD};
         {en3, en2, en1} <= {en2, en1, DRIVER_ENABLE_PIN};
         den_p <= den_q;
         if (BUS.wr && BUS.addr == A_DRV) begin
            den_q <= BUS.wdata[3:0];
            slw_q <= BUS.wdata[7:4];
            sio_q <= BUS.wdata[8];
         end
         oc_n <= (ILIM[0] && LINE.oe[0]) ? oc_n + 20'h00001 : '0;
         wk_n <= (|wk_oe) ? wk_n + 20'h00001 : '0;
         gap_n <= (|wk_oe) ? '0 : gap_n + 20'h00001;
         seen_q <= seen_q | (|wk_oe);
      end
   end
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (RST);
   a_rx_active: assert property (!$past(RST) |-> RXD_ACTIVE)
      else $error("receiver output inactive");
   a_drv_inverts: assert property (
      ((LINE.o ^ ~tx3) & LINE.oe & en1 & en2 & en3 & DRIVER_ENABLE_PIN
       & ~(tx1 ^ tx2) & ~(tx2 ^ tx3)) == '0)
      else $error("line drive not inverse of transmit data");
   a_sink_off: assert property ((LINE.oe & nz) == '0)
      else $error("sink on while port drives");
   a_slew_follow: assert property (
      slw_q == $past(slw_q) |-> SLEW_FAST == slw_q)
      else $error("edge rate output differs from register");
   a_oc_trip: assert property (
      oc_n <= (sio_q ? SIO_TRIP_CYC : OC_STD_CYC) + 4)
      else $error("breaker did not trip in time");
   a_wake_width: assert property (
      !(|wk_oe) && wk_n != 0 |-> wk_n == PULSE_CYC)
      else $error("wake pulse length wrong");
   a_wake_bound: assert property (wk_n <= PULSE_CYC)
      else $error("line driven without enable");
   a_one_wake: assert property ($onehot0(wk_oe))
      else $error("two ports pulse at once");
   a_cool_gap: assert property ($rose(|wk_oe) && seen_q
      |-> gap_n >= COOL_WAIT_CYC + SENSE_CYC)
      else $error("wake pulse inside cool-down");
   c_pulse_end: cover property ($fell(|wk_oe));
   c_trip: cover property (oc_n == OC_STD_CYC);
   c_second_wake: cover property ($rose(|wk_oe) && seen_q);
endmodule

bind qlw_top qlw_top_props #(
   .SIO_TRIP_CYC(SIO_TRIP_CYC),
   .COOL_WAIT_CYC(COOL_WAIT_CYC)
) props_u (
   .SYS_CLK(SYS_CLK), .RST(RST), .TXD(TXD), .DRIVER_ENABLE_PIN(DRIVER_ENABLE_PIN),
   .RXD_ACTIVE(RXD_ACTIVE), .BUS(BUS), .LINE(LINE), .ILIM(ILIM),
   .SINK_SEL(SINK_SEL), .SLEW_FAST(SLEW_FAST));

// ==== sim/qlw_remote.sv ====
// Remote sensor model on the four cabled lines.
`timescale 1ns/10ps
module qlw_remote (
   // Master side of the cable
   input  wire qlw_pkg::qlw_line_t          line,
   // Remote behaviour
   input  wire logic [qlw_pkg::NP-1:0]      lvl,
   input  wire logic [qlw_pkg::NP-1:0]      clamp,
   // Seen by the master
   output logic      [qlw_pkg::NP-1:0]      line_in,
   output logic      [qlw_pkg::NP-1:0]      ilim
);
   import qlw_pkg::*;
   // The remote output is weak, so an enabled master driver owns the wire.
   assign line_in = (line.o & line.oe) | (lvl & ~line.oe);
   // A clamped line loads the master into current limit only while it drives.
   assign ilim = clamp & line.oe;
endmodule

// ==== sim/qlw_top_tb.sv ====
// Self-checking testbench of the quad line transceiver wake-up block.
`timescale 1ns/10ps
module qlw_top_tb;
   import qlw_pkg::*;
   logic               sys_clk = 0, rst = 1, ot = 0, tsd = 0, rd_p = 0;
   logic [NP-1:0]      txd = '0, driver_enable_pin = '0, lvl = '0, clamp = '0;
   qlw_bus_t           bus = '0;
   logic [NP-1:0]      rxd, line_in, ilim, slew;
   logic               rxa, irq_o, irq_oe, thr;
   logic [DW-1:0]      rdata, exp_q[$];
   logic [NP-1:0][1:0] sink;
   qlw_line_t          line;
   logic [31:0]        r;
   int                 miscompares = 0, n_checks = 0, seed = 32'h97e8;
   int                 lim, thr_tab[4] = '{0, 1015, 140, 30};
   qlw_top #(.SIO_TRIP_CYC(40), .COOL_WAIT_CYC(50)) dut_u (
      .SYS_CLK(sys_clk), .RST(rst), .TXD(txd), .DRIVER_ENABLE_PIN(driver_enable_pin), .RXD(rxd),
      .RXD_ACTIVE(rxa), .BUS(bus), .REG_RDATA(rdata), .IRQ_O(irq_o),
      .IRQ_OE(irq_oe), .LINE_IN(line_in), .LINE(line), .ILIM(ilim),
      .OVERTEMP(ot), .THERM_SHDN(tsd), .SINK_SEL(sink), .SLEW_FAST(slew),
      .THRESH_TRACK(thr));
   qlw_remote rem_u (.line(line), .lvl(lvl), .clamp(clamp),
      .line_in(line_in), .ilim(ilim));
   initial begin
      forever #10 sys_clk = ~sys_clk;
   end
   task automatic chk(string nm, logic [DW-1:0] seen, logic [DW-1:0] ex);
      n_checks++;
      if (seen !== ex) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", nm, ex, seen);
      end
   endtask
   task automatic cyc(int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task automatic wr(logic [AW-1:0] a, logic [DW-1:0] d);
      @(posedge sys_clk) bus <= '{a, d, 1'b1, 1'b0};
      @(posedge sys_clk) bus <= '0;
   endtask
   task automatic rd(logic [AW-1:0] a, logic [DW-1:0] ex);
      exp_q.push_back(ex);
      @(posedge sys_clk) bus <= '{a, 16'h0000, 1'b0, 1'b1};
      @(posedge sys_clk) bus <= '0;
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // Read data stand only in the cycle after the strobe, so look there.
   always @(posedge sys_clk) begin
      if (rd_p) chk("rdata", rdata, exp_q.pop_front());
      rd_p <= bus.rd;
   end
   initial begin
      repeat (60000) @(posedge sys_clk);
      miscompares++;
      finish_test;
   end
   initial begin
      cyc(1);
      @(posedge sys_clk) rst <= 1'b0;
      for (int a = 0; a < 8; a++) rd(a[AW-1:0], '0);
      chk("rx_on", DW'(rxa), 16'h0001);
      $display("end reset values");
      r = $random(seed);
      wr(A_SINK, r[15:0]);
      wr(A_DRV, r[31:16] & 16'h0FF0);
      rd(A_SINK, {8'h00, r[7:0]});
      rd(A_DRV, r[31:16] & 16'h0FF0);
      for (int i = 0; i < NP; i++) begin
         chk("sink", DW'(sink[i]), DW'(r[2*i+:2]));
      end
      chk("slew", DW'(slew), DW'(r[23:20]));
      $display("end configuration");
      wr(A_DRV, '0);
      @(posedge sys_clk) driver_enable_pin <= 4'hF;
      for (int k = 0; k < 20; k++) begin
         @(posedge sys_clk) txd <= NP'($random(seed));
         cyc(9);
         chk("rxd", DW'(rxd), DW'(txd));
      end
      chk("track", DW'(thr), 16'h0001);
      // Open-drain use: data rides on the enable pins, transmit held high.
      for (int k = 0; k < 8; k++) begin
         @(posedge sys_clk) driver_enable_pin <= NP'($random(seed));
         txd <= 4'hF;
         cyc(5);
         chk("od", DW'({line.o, line.oe}), DW'(driver_enable_pin));
      end
      @(posedge sys_clk) driver_enable_pin <= '0;
      $display("end drive and receive");
      for (int c = 0; c < 4; c++) begin
         wr(A_FLT, DW'(c));
         @(posedge sys_clk) lvl[0] <= 1'b0;
         cyc(1100);
         if (thr_tab[c] > 0) begin
            @(posedge sys_clk) lvl[0] <= 1'b1;
            cyc(thr_tab[c] - 5);
            @(posedge sys_clk) lvl[0] <= 1'b0;
            cyc(thr_tab[c] + 10);
            chk("rxd0", DW'(rxd[0]), 16'h0001);
         end
         @(posedge sys_clk) lvl[0] <= 1'b1;
         cyc(thr_tab[c] + 10);
         chk("rxd0", DW'(rxd[0]), 16'h0000);
      end
      $display("end glitch filter");
      wr(A_SINK, 16'hFFFF);
      for (int m = 0; m < 2; m++) begin
         lim = m ? 40 : OC_STD_CYC;
         wr(A_MASK, DW'(m));
         wr(A_DRV, {7'h00, m[0], 8'h01});
         @(posedge sys_clk) clamp[0] <= 1'b1;
         cyc(lim - 10);
         rd(A_EVT, '0);
         cyc(30);
         rd(A_EVT, 16'h0001);
         chk("irq", DW'({irq_o, irq_oe}), DW'(m));
         @(posedge sys_clk) clamp[0] <= 1'b0;
         wr(A_EVT, '0);
         wr(A_DRV, '0);
         rd(A_EVT, '0);
      end
      $display("end overcurrent");
      wr(A_CTRL, 16'h0001);
      @(posedge sys_clk) lvl <= 4'h2;
      chk("track", DW'(thr), '0);
      wr(A_WAKE, 16'h0006);
      cyc(4);
      rd(A_STAT, 16'h0011);
      rd(A_WAKE, 16'h0004);
      wr(A_WAKE, 16'h0001);
      rd(A_WAKE, 16'h0004);
      cyc(300);
      chk("oe", DW'(line.oe), 16'h0002);
      chk("pol", DW'(line.o[1]), '0);
      chk("sink", DW'(sink[1]), '0);
      @(posedge sys_clk) ot <= 1'b1;
      cyc(4100);
      rd(A_STAT, 16'h0025);
      cyc(300);
      chk("oe", DW'(line.oe), '0);
      @(posedge sys_clk) ot <= 1'b0;
      cyc(300);
      chk("oe", DW'(line.oe), 16'h0004);
      chk("pol", DW'(line.o[2]), 16'h0001);
      cyc(4100);
      // Thermal shutdown held over a whole wake keeps the pulse off the line.
      @(posedge sys_clk) tsd <= 1'b1;
      wr(A_WAKE, 16'h0008);
      cyc(300);
      chk("oe", DW'(line.oe), '0);
      chk("sink", DW'(sink[3]), '0);
      rd(A_STAT, 16'h0039);
      cyc(4100);
      @(posedge sys_clk) tsd <= 1'b0;
      $display("end wake sequence");
      wr(A_CTRL, '0);
      wr(A_WAKE, 16'h0001);
      cyc(400);
      rd(A_WAKE, 16'h0001);
      chk("oe", DW'(line.oe), '0);
      $display("end wake disabled");
      cyc(2);
      finish_test;
   end
endmodule
